// ===== dacsp_pkg.sv
// Constants, field layouts and carrier types of the dual converter serial port
package dacsp_pkg;

   // Frame geometry
   localparam int FRAME_BITS   = 32;
   localparam int FRAME_CNT_W  = 16;
   localparam int FRAME_MOD_W  = 5;
   localparam int DATA_FIELD_W = 20;
   localparam int RES_DEFAULT  = 16;
   localparam int EXEC_CYC_DEF = 2;
   localparam int FIFO_DEPTH   = 4;

   // Command codes
   localparam logic [3:0] CMD_WR_IN      = 4'h0;
   localparam logic [3:0] CMD_UPD        = 4'h1;
   localparam logic [3:0] CMD_WR_UPD_ALL = 4'h2;
   localparam logic [3:0] CMD_WR_UPD     = 4'h3;
   localparam logic [3:0] CMD_PWR        = 4'h4;
   localparam logic [3:0] CMD_CLR_CODE   = 4'h5;
   localparam logic [3:0] CMD_LOAD_MASK  = 4'h6;
   localparam logic [3:0] CMD_SOFT_RST   = 4'h7;
   localparam logic [3:0] CMD_CHAIN      = 4'h8;

   // Channel select codes
   localparam logic [3:0] CHAN_A    = 4'h0;
   localparam logic [3:0] CHAN_B    = 4'h3;
   localparam logic [3:0] CHAN_BOTH = 4'hF;

   // Bit positions inside the data field
   localparam int PD_MODE_LSB = 8;
   localparam int PD_A_BIT    = 0;
   localparam int PD_B_BIT    = 3;
   localparam int CLR_LSB     = 0;
   localparam int MASK_A_BIT  = 0;
   localparam int MASK_B_BIT  = 3;
   localparam int CHAIN_BIT   = 1;

   // Reset values
   localparam logic [1:0] PWR_NORMAL  = 2'h0;
   localparam logic [1:0] CLR_RST     = 2'h0;
   localparam logic [1:0] MASK_RST    = 2'h0;
   localparam logic       CHAIN_RST   = 1'b0;
   localparam logic [3:0] CNT_ZERO    = 4'h0;

   typedef struct packed {
      logic [3:0]              ignored;
      logic [3:0]              cmd;
      logic [3:0]              chan;
      logic [DATA_FIELD_W-1:0] data;
   } dacsp_frame_t;

   typedef struct packed {
      logic [1:0] pwr_a;
      logic [1:0] pwr_b;
      logic [1:0] clr_sel;
      logic [1:0] load_mask;
      logic       chain_enable;
   } dacsp_mode_t;

endpackage : dacsp_pkg

// ===== dacsp_core.sv
// Serial command port, frame buffer and command executor of the dual converter
//
// Contract
// - A frame is 32 bits; the first four bits are ignored.
// - Next four bits are the command, then four channel select bits, MSB first.
// - Left-justified code follows; trailing filler bits are ignored.
// - Channel 0000 is A, 0011 is B, 1111 is both; others reserved.
// - Codes 0-3: write input, update, write and update all, write and update.
// - Codes 4-8: power, clear code, load mask, soft reset, chain enable.
// - Frame starts at sync fall; data sampled on falling serial clock edges.
// - On the 32nd falling edge the decoded command is carried out.
// - Sync rising before 32 edges clears the shift register, no effect.
// - Chain command takes chain_enable from DB1; reset value is standalone.
// - In chain mode extra clocks shift data out on rising edges.
// - Chain frames need 32N clocks; otherwise the frame is discarded.
// - Gated clock burst is latched by sync rising; no bits while high.
// - Codes are straight unsigned binary.
// - With load strobe high, converter registers update on its falling edge.
// - With load strobe low, converter registers update with the write.
`timescale 1ns/1ps

module dacsp_fifo #(
   parameter int W = 32,
   parameter int D = 4
) (
   // Clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   count_reg;
   logic          push;
   logic          pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (count_reg != (AW+1)'(D));
   assign out_valid = (count_reg != '0);
   assign out_data  = mem[rd_ptr_reg];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end

endmodule : dacsp_fifo

module dacsp_core #(
   parameter int RES         = dacsp_pkg::RES_DEFAULT,
   parameter int EXEC_CYCLES = dacsp_pkg::EXEC_CYC_DEF,
   parameter logic [RES-1:0] POR_CODE = '0
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_b,
   // Serial pins
   input  wire logic               frame_sync_n,
   input  wire logic               sclk,
   input  wire logic               din,
   output logic                    serial_out,
   // Load strobe pin
   input  wire logic               load_strobe_n,
   // Converter state
   output logic [RES-1:0]          conv_code_a,
   output logic [RES-1:0]          conv_code_b,
   output dacsp_pkg::dacsp_mode_t  mode
);
   import dacsp_pkg::*;

   typedef enum logic [1:0] {
      F_IDLE,
      F_SHIFT,
      F_HOLD
   } dacsp_fstate_t;

   // Channel select to {B, A} hit mask; reserved codes hit nothing
   function automatic logic [1:0] chan_hits(input logic [3:0] chan);
      case (chan)
         CHAN_A:    chan_hits = 2'b01;
         CHAN_B:    chan_hits = 2'b10;
         CHAN_BOTH: chan_hits = 2'b11;
         default:   chan_hits = 2'b00;
      endcase
   endfunction : chan_hits

   // Left-justified code of the configured resolution
   function automatic logic [RES-1:0] code_of(input logic [DATA_FIELD_W-1:0] d);
      code_of = d[DATA_FIELD_W-1 -: RES];
   endfunction : code_of

   // Pin synchronisers: sync, sclk, din, load strobe
   logic [3:0] pin_meta_reg;
   logic [3:0] pin_q_reg;
   logic [3:0] pin_prev_reg;
   logic       sync_q;
   logic       sclk_q;
   logic       din_q;
   logic       load_strobe_n_q;
   logic       sync_fall;
   logic       sync_rise;
   logic       sclk_fall;
   logic       sclk_rise;
   logic       load_strobe_n_fall;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg <= 4'hF;
         pin_q_reg    <= 4'hF;
         pin_prev_reg <= 4'hF;
      end else begin
         pin_meta_reg <= {load_strobe_n, din, sclk, frame_sync_n};
         pin_q_reg    <= pin_meta_reg;
         pin_prev_reg <= pin_q_reg;
      end
   end

   assign sync_q    = pin_q_reg[0];
   assign sclk_q    = pin_q_reg[1];
   assign din_q     = pin_q_reg[2];
   assign load_strobe_n_q    = pin_q_reg[3];
   assign sync_fall = pin_prev_reg[0] && !sync_q;
   assign sync_rise = !pin_prev_reg[0] && sync_q;
   assign sclk_fall = pin_prev_reg[1] && !sclk_q;
   assign sclk_rise = !pin_prev_reg[1] && sclk_q;
   assign load_strobe_n_fall = pin_prev_reg[3] && !load_strobe_n_q;

   // Frame capture
   dacsp_fstate_t           fstate_reg;
   logic [FRAME_BITS-1:0]   shift_reg;
   logic [FRAME_CNT_W-1:0]  edge_cnt_reg;
   logic                    pend_valid_reg;
   dacsp_frame_t            pend_word_reg;
   logic                    pend_ready;
   logic [FRAME_BITS-1:0]   shift_next;
   logic                    chain_en;
   logic                    chain_full;

   assign shift_next = {shift_reg[FRAME_BITS-2:0], din_q};
   assign chain_en   = mode.chain_enable;
   // Whole multiple of 32 edges, at least one frame
   assign chain_full = (edge_cnt_reg != '0)
                       && (edge_cnt_reg[FRAME_MOD_W-1:0] == '0);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         fstate_reg   <= F_IDLE;
         shift_reg    <= '0;
         edge_cnt_reg <= '0;
      end else begin
         case (fstate_reg)
            F_IDLE: begin
               if (sync_fall) begin
                  fstate_reg   <= F_SHIFT;
                  shift_reg    <= '0;
                  edge_cnt_reg <= '0;
               end
            end
            F_SHIFT: begin
               if (sync_rise) begin
                  // Early rise or partial chain frame discards the data
                  if (!(chain_en && chain_full)) begin
                     shift_reg <= '0;
                  end
                  fstate_reg <= F_IDLE;
               end else if (sclk_fall) begin
                  shift_reg <= shift_next;
                  if (edge_cnt_reg != '1) begin
                     edge_cnt_reg <= edge_cnt_reg + 1'b1;
                  end
                  if (!chain_en && edge_cnt_reg == FRAME_CNT_W'(FRAME_BITS - 1)) begin
                     fstate_reg <= F_HOLD;
                  end
               end
            end
            F_HOLD: begin
               // Standalone frame done; further clocks are ignored
               if (sync_rise) begin
                  fstate_reg <= F_IDLE;
               end
            end
            default: begin
               fstate_reg <= F_IDLE;
            end
         endcase
      end
   end

   // Completed frame waits here until the buffer accepts it
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pend_valid_reg <= 1'b0;
         pend_word_reg  <= '0;
      end else if (fstate_reg == F_SHIFT && !sync_rise && sclk_fall && !chain_en
                   && edge_cnt_reg == FRAME_CNT_W'(FRAME_BITS - 1)) begin
         pend_valid_reg <= 1'b1;
         pend_word_reg  <= shift_next;
      end else if (fstate_reg == F_SHIFT && sync_rise && chain_en && chain_full) begin
         pend_valid_reg <= 1'b1;
         pend_word_reg  <= shift_reg;
      end else if (pend_ready) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // Serial output moves on rising clock, stable at the next falling edge
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         serial_out <= 1'b0;
      end else if (!chain_en) begin
         serial_out <= 1'b0;
      end else if (fstate_reg == F_SHIFT && sclk_rise) begin
         serial_out <= shift_reg[FRAME_BITS-1];
      end
   end

   // Frame buffer between capture and execution
   dacsp_frame_t fifo_word;
   logic         fifo_valid;
   logic         exec_ready;
   logic [3:0]   busy_cnt_reg;
   logic         take;

   dacsp_fifo #(
      .W (FRAME_BITS),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (pend_valid_reg),
      .in_ready  (pend_ready),
      .in_data   (pend_word_reg),
      .out_valid (fifo_valid),
      .out_ready (exec_ready),
      .out_data  (fifo_word)
   );

   // Executor accepts one command every EXEC_CYCLES cycles
   assign exec_ready = (busy_cnt_reg == CNT_ZERO);
   assign take       = fifo_valid && exec_ready;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         busy_cnt_reg <= CNT_ZERO;
      end else if (take) begin
         busy_cnt_reg <= 4'(EXEC_CYCLES - 1);
      end else if (busy_cnt_reg != CNT_ZERO) begin
         busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
   end

   // Command decode
   logic [1:0]     hits;
   logic [RES-1:0] new_code;
   logic [1:0]     sync_upd;
   logic [RES-1:0] in_reg   [2];
   logic [RES-1:0] conv_reg [2];

   assign hits     = chan_hits(fifo_word.chan);
   assign new_code = code_of(fifo_word.data);
   // Strobe held low, or masked channel, updates with the write
   assign sync_upd = {2{!load_strobe_n_q}} | mode.load_mask;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         in_reg[0]   <= '0;
         in_reg[1]   <= '0;
         conv_reg[0] <= '0;
         conv_reg[1] <= '0;
      end else begin
         if (load_strobe_n_fall) begin
            conv_reg[0] <= in_reg[0];
            conv_reg[1] <= in_reg[1];
         end
         if (take) begin
            for (int ch = 0; ch < 2; ch++) begin
               case (fifo_word.cmd)
                  CMD_WR_IN: begin
                     if (hits[ch]) begin
                        in_reg[ch] <= new_code;
                        if (sync_upd[ch]) begin
                           conv_reg[ch] <= new_code;
                        end
                     end
                  end
                  CMD_UPD: begin
                     if (hits[ch]) begin
                        conv_reg[ch] <= in_reg[ch];
                     end
                  end
                  CMD_WR_UPD_ALL: begin
                     if (hits != 2'b00) begin
                        if (hits[ch]) begin
                           in_reg[ch]   <= new_code;
                           conv_reg[ch] <= new_code;
                        end else begin
                           conv_reg[ch] <= in_reg[ch];
                        end
                     end
                  end
                  CMD_WR_UPD: begin
                     if (hits[ch]) begin
                        in_reg[ch]   <= new_code;
                        conv_reg[ch] <= new_code;
                     end
                  end
                  CMD_SOFT_RST: begin
                     in_reg[ch]   <= POR_CODE;
                     conv_reg[ch] <= POR_CODE;
                  end
                  default: begin
                     // Other commands leave the codes alone
                  end
               endcase
            end
         end
      end
   end

   assign conv_code_a = conv_reg[0];
   assign conv_code_b = conv_reg[1];

   // Operating mode registers
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mode.pwr_a        <= PWR_NORMAL;
         mode.pwr_b        <= PWR_NORMAL;
         mode.clr_sel      <= CLR_RST;
         mode.load_mask    <= MASK_RST;
         mode.chain_enable <= CHAIN_RST;
      end else if (take) begin
         case (fifo_word.cmd)
            CMD_PWR: begin
               if (fifo_word.data[PD_A_BIT]) begin
                  mode.pwr_a <= fifo_word.data[PD_MODE_LSB +: 2];
               end
               if (fifo_word.data[PD_B_BIT]) begin
                  mode.pwr_b <= fifo_word.data[PD_MODE_LSB +: 2];
               end
            end
            CMD_CLR_CODE: begin
               mode.clr_sel <= fifo_word.data[CLR_LSB +: 2];
            end
            CMD_LOAD_MASK: begin
               mode.load_mask <= {fifo_word.data[MASK_B_BIT],
                                  fifo_word.data[MASK_A_BIT]};
            end
            CMD_SOFT_RST: begin
               mode.pwr_a        <= PWR_NORMAL;
               mode.pwr_b        <= PWR_NORMAL;
               mode.clr_sel      <= CLR_RST;
               mode.load_mask    <= MASK_RST;
               mode.chain_enable <= CHAIN_RST;
            end
            CMD_CHAIN: begin
               mode.chain_enable <= fifo_word.data[CHAIN_BIT];
            end
            default: begin
               // Reserved codes change nothing
            end
         endcase
      end
   end

endmodule : dacsp_core

// ===== dacsp_core_properties.sv
// Concurrent checks on the serial command port
`timescale 1ns/1ps
module dacsp_props
   import dacsp_pkg::*;
#(
   parameter int RES = RES_DEFAULT
) (
   // Clock and reset
   input wire logic                   clk_sys,
   input wire logic                   rst_b,
   // Pins
   input wire logic                   frame_sync_n,
   input wire logic                   sclk,
   input wire logic                   din,
   input wire logic                   serial_out,
   input wire logic                   load_strobe_n,
   // Converter state
   input wire logic [RES-1:0]         conv_code_a,
   input wire logic [RES-1:0]         conv_code_b,
   input wire dacsp_pkg::dacsp_mode_t mode
);
   logic [3:0] quiet_reg;
   logic [3:0] hi_reg;
   logic [3:0] still_reg;
   logic       sclk_reg;

   function automatic logic [3:0] sat(input logic [3:0] c);
      return (c == 4'hF) ? c : c + 4'h1;
   endfunction : sat

   // Idle counters; 15 cycles outlasts the whole execute pipeline
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         quiet_reg <= 4'h0;
         hi_reg    <= 4'h0;
         still_reg <= 4'h0;
         sclk_reg  <= 1'b0;
      end else begin
         sclk_reg  <= sclk;
         quiet_reg <= (frame_sync_n && load_strobe_n) ? sat(quiet_reg) : 4'h0;
         hi_reg    <= frame_sync_n ? sat(hi_reg) : 4'h0;
         still_reg <= (!frame_sync_n && load_strobe_n && sclk == sclk_reg) ?
                      sat(still_reg) : 4'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   sequence s_strobe_fall;
      $fell(load_strobe_n) && hi_reg == 4'hF;
   endsequence
   sequence s_link_rise;
      $past(sclk, 2) && !$past(sclk, 7);
   endsequence

   property p_reset_values;
      $rose(rst_b) |-> conv_code_a == '0 && conv_code_b == '0 && mode == '0;
   endproperty
   property p_out_quiet;
      !mode.chain_enable && !$past(mode.chain_enable) && !$past(mode.chain_enable, 2)
         |-> !serial_out;
   endproperty
   property p_idle_stable;
      quiet_reg == 4'hF |=> $stable(conv_code_a) && $stable(conv_code_b);
   endproperty
   property p_mode_sync;
      hi_reg == 4'hF |=> $stable(mode);
   endproperty
   property p_serial_idle;
      hi_reg == 4'hF |=> $stable(serial_out);
   endproperty
   property p_low_idle;
      still_reg == 4'hF |=> $stable(conv_code_a) && $stable(mode);
   endproperty
   property p_strobe_once;
      s_strobe_fall ##1 frame_sync_n [*8] |=> $stable(conv_code_a) && $stable(conv_code_b);
   endproperty
   property p_out_edge;
      mode.chain_enable && $past(mode.chain_enable) && !frame_sync_n && $changed(serial_out)
         |-> s_link_rise;
   endproperty

   a_reset_values: assert property (p_reset_values) else $error("bad reset state");
   a_out_quiet: assert property (p_out_quiet) else $error("serial_out active");
   a_idle_stable: assert property (p_idle_stable) else $error("code changed idle");
   a_mode_sync: assert property (p_mode_sync) else $error("mode changed idle");
   a_serial_idle: assert property (p_serial_idle) else $error("serial_out moved");
   a_low_idle: assert property (p_low_idle) else $error("change without edges");
   a_strobe_once: assert property (p_strobe_once) else $error("late strobe update");
   a_out_edge: assert property (p_out_edge) else $error("serial_out off edge");
endmodule : dacsp_props

bind dacsp_core dacsp_props #(.RES(RES)) dacsp_props_i (
   .clk_sys(clk_sys), .rst_b(rst_b), .frame_sync_n(frame_sync_n), .sclk(sclk), .din(din),
   .serial_out(serial_out), .load_strobe_n(load_strobe_n), .conv_code_a(conv_code_a),
   .conv_code_b(conv_code_b), .mode(mode)
);

// ===== dacsp_master_model.sv
// Behavioural serial master for the command port link pins
`timescale 1ns/1ps
module dacsp_master_model (
   // Link pins
   output logic      frame_sync_n,
   output logic      sclk,
   output logic      din,
   input  wire logic serial_out
);
   logic [63:0] so_cap;

   initial begin
      frame_sync_n = 1'b1;
      sclk         = 1'b0;
      din          = 1'b0;
      so_cap       = '0;
   end

   // Low n bits of d, first bit first; idle leaves sync low afterwards
   task automatic send(input logic [63:0] d, input int n, input bit idle);
      int i;
      if (!frame_sync_n) begin
         frame_sync_n = 1'b1;
         #2000;
      end
      frame_sync_n = 1'b0;
      #62.5;
      for (i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         #10 din = d[i];
         #52.5 sclk = 1'b0;
         so_cap = {so_cap[62:0], serial_out};
         if (i > 0) #62.5;
      end
      #20 frame_sync_n = 1'b1;
      din = ~din;
      #2000;
      if (idle) frame_sync_n = 1'b0;
   endtask : send
endmodule : dacsp_master_model

// ===== dual_dac_serial_command_port_test.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
module dual_dac_serial_command_port_test;
   import dacsp_pkg::*;
   logic        clk_sys;
   logic        rst_b;
   logic        frame_sync_n;
   logic        sclk;
   logic        din;
   logic        serial_out;
   logic        load_strobe_n;
   logic [15:0] conv_code_a;
   logic [15:0] conv_code_b;
   dacsp_mode_t mode;
   dacsp_mode_t exp_m;
   logic [15:0] in_a;
   logic [15:0] in_b;
   logic [15:0] exp_a;
   logic [15:0] exp_b;
   int          errors;
   int          tests_run;
   int          cycles;

   dacsp_core dacsp_core_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .frame_sync_n(frame_sync_n), .sclk(sclk), .din(din),
      .serial_out(serial_out), .load_strobe_n(load_strobe_n), .conv_code_a(conv_code_a),
      .conv_code_b(conv_code_b), .mode(mode)
   );
   dacsp_master_model master_i (
      .frame_sync_n(frame_sync_n), .sclk(sclk), .din(din), .serial_out(serial_out)
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic finish_test;
      if (errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         finish_test();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_st;
      chk(64'(conv_code_a), 64'(exp_a));
      chk(64'(conv_code_b), 64'(exp_b));
      chk(64'(mode), 64'(exp_m));
   endtask : chk_st

   // Frames start just after a clock edge, like every other stimulus
   task automatic align;
      @(posedge clk_sys);
      #1;
   endtask : align

   task automatic strobe(input logic v);
      @(posedge clk_sys);
      #1 load_strobe_n = v;
      repeat (10) @(posedge clk_sys);
   endtask : strobe

   // One frame plus the expected effect on input and converter codes
   task automatic op(input logic [3:0] c, input logic [3:0] ch, input logic [19:0] f);
      logic sa;
      logic sb;
      logic up;
      logic w;
      sa = (ch == CHAN_A || ch == CHAN_BOTH) && c <= CMD_WR_UPD;
      sb = (ch == CHAN_B || ch == CHAN_BOTH) && c <= CMD_WR_UPD;
      up = (sa || sb) && c == CMD_WR_UPD_ALL;
      w  = c != CMD_WR_IN || !load_strobe_n;
      align();
      master_i.send({32'h0, 4'hA, c, ch, f}, 32, 1'b0);
      if (sa && c != CMD_UPD) in_a = f[19:4];
      if (sb && c != CMD_UPD) in_b = f[19:4];
      if (up || sa && (w || exp_m.load_mask[0])) exp_a = in_a;
      if (up || sb && (w || exp_m.load_mask[1])) exp_b = in_b;
   endtask : op

   task automatic t_async;
      op(CMD_WR_IN, CHAN_A, 20'h1_111F);
      chk_st();
      strobe(1'b0);
      exp_a = in_a;
      exp_b = in_b;
      strobe(1'b1);
      chk_st();
      op(CMD_WR_IN, CHAN_B, 20'h2_222F);
      op(CMD_UPD, CHAN_B, 20'h0_0000);
      chk_st();
   endtask : t_async

   task automatic t_cmds;
      op(CMD_WR_IN, CHAN_A, 20'h3_333F);
      op(CMD_WR_UPD_ALL, CHAN_B, 20'h4_444F);
      chk_st();
      op(CMD_WR_UPD, CHAN_BOTH, 20'hF_FFFF);
      chk_st();
      op(CMD_WR_UPD, CHAN_A, 20'h0_0000);
      chk_st();
      strobe(1'b0);
      op(CMD_WR_IN, CHAN_B, 20'h8_0010);
      chk_st();
      strobe(1'b1);
   endtask : t_cmds

   task automatic t_reserved;
      logic [3:0] c;
      for (c = 4'h9; c != 4'h0; c++) op(c, CHAN_A, 20'h5_555F);
      chk_st();
      op(CMD_WR_UPD, 4'h1, 20'h5_555F);
      op(CMD_WR_UPD, 4'h2, 20'h5_555F);
      chk_st();
   endtask : t_reserved

   task automatic t_abort;
      align();
      master_i.send({32'h0, 4'hA, CMD_WR_UPD, CHAN_A, 20'h6_666F} >> 12, 20, 1'b1);
      chk_st();
      op(CMD_WR_UPD, CHAN_A, 20'h7_777F);
      chk_st();
   endtask : t_abort

   task automatic t_modes;
      op(CMD_PWR, CHAN_A, 20'h0_0201);
      exp_m.pwr_a = 2'h2;
      op(CMD_CLR_CODE, CHAN_A, 20'h0_0001);
      exp_m.clr_sel = 2'h1;
      op(CMD_LOAD_MASK, CHAN_A, 20'h0_0008);
      exp_m.load_mask = 2'h2;
      chk_st();
      op(CMD_WR_IN, CHAN_B, 20'h9_ABCF);
      chk_st();
      op(CMD_CHAIN, CHAN_B, 20'h0_0001);
      chk_st();
      op(CMD_CHAIN, 4'h5, 20'h0_0002);
      exp_m.chain_enable = 1'b1;
      chk_st();
   endtask : t_modes

   task automatic t_chain;
      align();
      master_i.send({32'h1234_5678, 4'hA, CMD_WR_UPD, CHAN_A, 20'h5_A5AF}, 64, 1'b0);
      in_a  = 16'h5A5A;
      exp_a = in_a;
      chk(64'(master_i.so_cap[31:0]), 64'h1234_5678);
      chk_st();
      align();
      master_i.send({24'h0, 8'hFF, 4'hA, CMD_WR_UPD, CHAN_A, 20'h0_F0FF}, 40, 1'b0);
      chk_st();
      align();
      master_i.send({32'h0, 4'hA, CMD_SOFT_RST, CHAN_A, 20'h0_0000}, 32, 1'b0);
      in_a  = '0;
      in_b  = '0;
      exp_a = '0;
      exp_b = '0;
      exp_m = '0;
      chk_st();
   endtask : t_chain

   initial begin
      errors        = 0;
      tests_run     = 0;
      rst_b         = 1'b0;
      load_strobe_n = 1'b1;
      in_a          = '0;
      in_b          = '0;
      exp_a         = '0;
      exp_b         = '0;
      exp_m         = '0;
      repeat (2) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      repeat (10) @(posedge clk_sys);
      chk_st();
      t_async();
      t_cmds();
      t_reserved();
      t_abort();
      t_modes();
      t_chain();
      finish_test();
   end
endmodule : dual_dac_serial_command_port_test
